// ===== logic/lsch_bank_store.sv
// Set-up store for saved setpoint images, one word per setpoint.
// Assumes the caller holds addresses steady; read data arrive one cycle later.
module lsch_bank_store
   import lsch_pkg::*;
(
   input wire logic core_clk,
   input wire logic wrEn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [SP_W-1:0] wrData,
   output logic [SP_W-1:0] rdData
);
   // No reset: contents stand for non-volatile storage
   logic [SP_W-1:0] mem [STORE_DEPTH];

   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         mem[addr] <= wrData;
      end
      rdData <= mem[addr];
   end
endmodule

// ===== logic/lsch_dyn_wave.sv
// Microsecond tick and high/low dwell alternation for the dynamic waveform.
// Assumes dwell times in 1e-5 ms; resolution is one microsecond.
module lsch_dyn_wave
   import lsch_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [SP_W-1:0] highDwell,
   input wire logic [SP_W-1:0] lowDwell,
   output logic tickPulse,
   output logic phaseHigh
);
   logic [5:0] tickCnt_reg;
   logic [SP_W-1:0] elapsed_reg;
   wire tickHit = tickCnt_reg == TICK_LAST;
   wire [SP_W-1:0] dwell = phaseHigh ? highDwell : lowDwell;
   wire [SP_W-1:0] elapsedInc = elapsed_reg + UNITS_PER_TICK;
   wire dwellDone = elapsedInc >= dwell;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tickCnt_reg <= 6'h0;
         tickPulse <= 1'b0;
      end else begin
         tickCnt_reg <= tickHit ? 6'h0 : tickCnt_reg + 6'h1;
         tickPulse <= tickHit;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || !run) begin
         elapsed_reg <= SP_RESET;
         phaseHigh <= 1'b0;
      end else if (tickHit && dwellDone) begin
         elapsed_reg <= SP_RESET;
         phaseHigh <= !phaseHigh;
      end else if (tickHit) begin
         elapsed_reg <= elapsedInc;
      end
   end
endmodule

// ===== logic/lsch_handler.sv
// Setpoint command handler of an electronic DC load: parsed commands in, stored setpoints out.
// Assumes a front end that turns host text into one cycle command strobes with fixed-point values.
module lsch_handler
   import lsch_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cmdValid,
   input wire logic [1:0] cmdOp,
   input wire logic [IDX_W-1:0] cmdTarget,
   input wire logic cmdQuery,
   input wire logic cmdHasArg,
   input wire logic cmdHasPoint,
   input wire logic cmdTerm,
   input wire logic [SP_W-1:0] cmdValue,
   input wire logic [3:0] cmdState,
   input wire logic [3:0] cmdBank,
   input wire logic [SP_W-1:0] maxSlew,
   input wire logic [SP_W-1:0] maxPeriod,
   input wire logic [SP_W-1:0] maxVolt,
   input wire logic [SP_W-1:0] maxCurrent,
   input wire logic [SP_W-1:0] maxPower,
   input wire logic [SP_W-1:0] maxRes,
   input wire logic [SP_W-1:0] measVolt,
   input wire logic [SP_W-1:0] measCurrent,
   input wire logic dynEnable,
   input wire logic levelSelHigh,
   input wire logic singleLevel,
   input wire logic ngEnable,
   output logic cmdBusy,
   output logic rspValid,
   output logic rspError,
   output logic [SP_W-1:0] rspData,
   output logic [SP_W-1:0] slewRise,
   output logic [SP_W-1:0] slewFall,
   output logic [SP_W-1:0] currentDrive,
   output logic [SP_W-1:0] powerDrive,
   output logic [SP_W-1:0] resDrive,
   output logic waveHigh,
   output logic loadOn,
   output logic limitFail
);
   // ***************************************************
   // Decoding helpers
   // ***************************************************
   function automatic logic isLowIdx(input logic [IDX_W-1:0] i);
      return i == IDX_CC_LO || i == IDX_CP_LO || i == IDX_CR_LO || i == IDX_LIM_LO;
   endfunction

   function automatic logic isHighIdx(input logic [IDX_W-1:0] i);
      return i == IDX_CC_HI || i == IDX_CP_HI || i == IDX_CR_HI || i == IDX_LIM_HI;
   endfunction

   function automatic lsch_class_t spClass(input logic [IDX_W-1:0] i);
      lsch_class_t c;
      c = CLS_CURRENT_SETPOINT_CMD;
      if (i == IDX_RISE || i == IDX_FALL) c = CLS_SLEW;
      else if (i == IDX_T_HIGH || i == IDX_T_LOW) c = CLS_TIME;
      else if (i == IDX_V_ON || i == IDX_V_OFF) c = CLS_VOLT;
      else if (i == IDX_CP_HI || i == IDX_CP_LO) c = CLS_POW;
      else if (i == IDX_CR_HI || i == IDX_CR_LO) c = CLS_RES;
      return c;
   endfunction

   // ***************************************************
   // State and storage
   // ***************************************************
   lsch_state_t state_reg;
   logic [SP_W-1:0] sp_reg [SP_NUM];
   logic [IDX_W-1:0] word_reg;
   logic [SLOT_W-1:0] slot_reg;
   logic rdPend_reg;
   logic [IDX_W-1:0] rdIdx_reg;
   logic [SP_W-1:0] storeRd;
   logic tick;
   logic [SP_W-1:0] limHi;
   logic [SP_W-1:0] limLo;

   // ***************************************************
   // Command decode
   // ***************************************************
   wire accept = cmdValid && state_reg == ST_IDLE;
   wire isSet = cmdOp == OP_SET;
   wire isSave = cmdOp == OP_SAVE;
   wire isRecall = cmdOp == OP_RECALL;
   wire validTarget = cmdTarget != IDX_SPARE;
   wire isWrite = isSet && !cmdQuery;
   wire isPeriod = cmdTarget == IDX_T_HIGH || cmdTarget == IDX_T_LOW;
   wire [IDX_W-1:0] partner = isLowIdx(cmdTarget) ? cmdTarget - IDX_ONE : cmdTarget + IDX_ONE;
   wire lsch_class_t cls = spClass(cmdTarget);
   wire [SP_W-1:0] classMax = cls == CLS_SLEW ? maxSlew : cls == CLS_TIME ? maxPeriod :
      cls == CLS_VOLT ? maxVolt : cls == CLS_POW ? maxPower : cls == CLS_RES ? maxRes : maxCurrent;
   // Finer digits of the rise slew are dropped, not rounded
   wire [SP_W-1:0] rounded = cmdTarget == IDX_RISE ? (cmdValue / RISE_QUANTUM) * RISE_QUANTUM : cmdValue;
   wire [SP_W-1:0] clamped = rounded > classMax ? classMax : rounded;
   wire orderBad = (isLowIdx(cmdTarget) && clamped > sp_reg[partner]) ||
      (isHighIdx(cmdTarget) && clamped < sp_reg[partner]);
   wire argBad = !cmdHasArg || (isPeriod && !cmdHasPoint);
   wire slotBad = cmdState < STATE_MIN || cmdState > STATE_MAX || cmdBank < BANK_MIN || cmdBank > BANK_MAX;
   wire setBad = !validTarget || (isWrite && (argBad || orderBad));
   wire cmdBad = !cmdTerm || (isSet ? setBad : (isSave || isRecall) ? slotBad : 1'b1);
   wire setWe = accept && isWrite && !cmdBad;
   wire [SLOT_W-1:0] slotCalc = SLOT_W'((SLOT_W'(cmdBank) - SLOT_W'(BANK_MIN)) * STATES_PER_BANK +
      (SLOT_W'(cmdState) - SLOT_W'(STATE_MIN)));
   wire lastWord = word_reg == IDX_SPARE;
   wire [ADDR_W-1:0] storeAddr = {slot_reg, word_reg};
   wire storeWe = state_reg == ST_SAVE;

   // ***************************************************
   // Sequencer for save and recall
   // ***************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         word_reg <= 4'h0;
         slot_reg <= 8'h00;
         rdPend_reg <= 1'b0;
         rdIdx_reg <= 4'h0;
      end else begin
         rdPend_reg <= state_reg == ST_RECALL;
         rdIdx_reg <= word_reg;
         unique case (state_reg)
            ST_IDLE: begin
               word_reg <= 4'h0;
               slot_reg <= slotCalc;
               if (accept && !cmdBad && isSave) state_reg <= ST_SAVE;
               else if (accept && !cmdBad && isRecall) state_reg <= ST_RECALL;
            end
            ST_SAVE: begin
               word_reg <= word_reg + IDX_ONE;
               if (lastWord) state_reg <= ST_IDLE;
            end
            ST_RECALL: begin
               word_reg <= word_reg + IDX_ONE;
               if (lastWord) state_reg <= ST_DRAIN;
            end
            ST_DRAIN: begin
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   lsch_bank_store store (
      .core_clk(core_clk),
      .wrEn(storeWe),
      .addr(storeAddr),
      .wrData(sp_reg[word_reg]),
      .rdData(storeRd)
   );

   // ***************************************************
   // Setpoint words
   // ***************************************************
   // Each word has its own storage, so a write touches one word only
   for (genvar i = 0; i < SP_NUM; i++) begin : gen_sp
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            sp_reg[i] <= SP_RESET;
         end else if (setWe && cmdTarget == IDX_W'(i)) begin
            sp_reg[i] <= clamped;
         end else if (rdPend_reg && rdIdx_reg == IDX_W'(i)) begin
            sp_reg[i] <= storeRd;
         end
      end
   end

   // ***************************************************
   // Answers to the host
   // ***************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rspValid <= 1'b0;
         rspError <= 1'b0;
         rspData <= SP_RESET;
         cmdBusy <= 1'b0;
      end else begin
         rspValid <= (accept && (cmdBad || isSet)) || (storeWe && lastWord) || state_reg == ST_DRAIN;
         rspError <= accept && cmdBad;
         rspData <= (accept && isSet && cmdQuery && !cmdBad) ? sp_reg[cmdTarget] : SP_RESET;
         cmdBusy <= (accept && !cmdBad && !isSet) || (state_reg != ST_IDLE && state_reg != ST_DRAIN &&
            !(storeWe && lastWord));
      end
   end

   // ***************************************************
   // Load drive: level selection and slewing
   // ***************************************************
   lsch_dyn_wave wave (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .run(dynEnable),
      .highDwell(sp_reg[IDX_T_HIGH]),
      .lowDwell(sp_reg[IDX_T_LOW]),
      .tickPulse(tick),
      .phaseHigh(waveHigh)
   );

   wire selHigh = dynEnable ? waveHigh : levelSelHigh;
   wire [SP_W-1:0] currentGoal = singleLevel ? sp_reg[IDX_CC] : selHigh ? sp_reg[IDX_CC_HI] : sp_reg[IDX_CC_LO];
   wire [SP_W-1:0] upGap = currentGoal - currentDrive;
   wire [SP_W-1:0] downGap = currentDrive - currentGoal;
   assign slewRise = sp_reg[IDX_RISE];
   assign slewFall = sp_reg[IDX_FALL];
   assign limHi = sp_reg[IDX_LIM_HI];
   assign limLo = sp_reg[IDX_LIM_LO];

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         currentDrive <= SP_RESET;
         powerDrive <= SP_RESET;
         resDrive <= SP_RESET;
      end else begin
         powerDrive <= selHigh ? sp_reg[IDX_CP_HI] : sp_reg[IDX_CP_LO];
         resDrive <= selHigh ? sp_reg[IDX_CR_HI] : sp_reg[IDX_CR_LO];
         // Slew is applied once per microsecond in A/us, so one step is the rate itself
         if (tick && currentGoal > currentDrive) begin
            currentDrive <= upGap > slewRise ? currentDrive + slewRise : currentGoal;
         end else if (tick && currentGoal < currentDrive) begin
            currentDrive <= downGap > slewFall ? currentDrive - slewFall : currentGoal;
         end
      end
   end

   // ***************************************************
   // Automatic switching and limit check
   // ***************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         loadOn <= 1'b0;
         limitFail <= 1'b0;
      end else begin
         if (!loadOn && measVolt >= sp_reg[IDX_V_ON]) loadOn <= 1'b1;
         else if (loadOn && measVolt <= sp_reg[IDX_V_OFF]) loadOn <= 1'b0;
         limitFail <= ngEnable && (measCurrent > limHi || measCurrent < limLo);
      end
   end

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   query_reply_a: assert property (accept && isSet && cmdQuery && cmdTerm && validTarget |=>
      rspValid && !rspError && rspData == sp_reg[$past(cmdTarget)]) else $error("query answer wrong");
   missing_arg_a: assert property (accept && isWrite && !cmdHasArg |=>
      rspError && sp_reg[$past(cmdTarget)] == $past(sp_reg[cmdTarget])) else $error("write without argument stored");
   period_point_a: assert property (accept && isWrite && isPeriod && !cmdHasPoint |=>
      rspValid && rspError) else $error("period without point taken");
   no_term_a: assert property (accept && !cmdTerm |=> rspError ##1 !cmdBusy)
      else $error("unterminated command accepted");
   clamp_max_a: assert property (setWe |=> sp_reg[$past(cmdTarget)] <= $past(classMax))
      else $error("stored value above maximum");
   rise_quant_a: assert property (sp_reg[IDX_RISE] % RISE_QUANTUM == SP_RESET)
      else $error("rise slew finer than four decimals");
   slew_split_a: assert property (setWe && cmdTarget == IDX_RISE |=> $stable(sp_reg[IDX_FALL]))
      else $error("rise write changed fall slew");
   cc_order_a: assert property (sp_reg[IDX_CC_LO] <= sp_reg[IDX_CC_HI])
      else $error("low current above high");
   cp_order_a: assert property (sp_reg[IDX_CP_LO] <= sp_reg[IDX_CP_HI])
      else $error("low power above high");
   cr_order_a: assert property (sp_reg[IDX_CR_LO] <= sp_reg[IDX_CR_HI])
      else $error("low resistance above high");
   ramp_rise_a: assert property (tick && currentGoal > currentDrive |=>
      currentDrive > $past(currentDrive) && currentDrive - $past(currentDrive) <= $past(slewRise))
      else $error("rise ramp step wrong");
   ramp_fall_a: assert property (tick && currentGoal < currentDrive |=>
      currentDrive < $past(currentDrive) && $past(currentDrive) - currentDrive <= $past(slewFall))
      else $error("fall ramp step wrong");
   switch_on_a: assert property (!loadOn && measVolt >= sp_reg[IDX_V_ON] |=> loadOn)
      else $error("load failed to switch on");
   switch_off_a: assert property (loadOn && measVolt <= sp_reg[IDX_V_OFF] |=> !loadOn)
      else $error("load failed to switch off");
   limit_flag_a: assert property (ngEnable && measCurrent > limHi |=> limitFail)
      else $error("limit fail flag missing");
   save_busy_a: assert property (accept && isSave && !cmdBad |=> cmdBusy [*8])
      else $error("save sequence not busy");
   dwell_hold_a: assert property (dynEnable && $rose(waveHigh) |=> waveHigh [*8])
      else $error("high phase shorter than a tick");

   query_seen_c: cover property (accept && isSet && cmdQuery && !cmdBad);
   clamp_seen_c: cover property (setWe && rounded > classMax);
   recall_done_c: cover property (state_reg == ST_DRAIN);
   wave_flip_c: cover property (dynEnable && $fell(waveHigh));
endmodule

// ===== logic/lsch_pkg.sv
// Constants, setpoint map and state codes for the load setpoint command handler.
// Assumes one 40 MHz clock and values in fixed point, 1e-5 of the engineering unit.
package lsch_pkg;
   // ***************************************************
   // Widths and setpoint map
   // ***************************************************
   localparam int unsigned SP_W = 32;
   localparam int unsigned IDX_W = 4;
   localparam int unsigned SP_NUM = 16;
   localparam logic [3:0] IDX_RISE = 4'h0;
   localparam logic [3:0] IDX_FALL = 4'h1;
   localparam logic [3:0] IDX_T_HIGH = 4'h2;
   localparam logic [3:0] IDX_T_LOW = 4'h3;
   localparam logic [3:0] IDX_V_ON = 4'h4;
   localparam logic [3:0] IDX_V_OFF = 4'h5;
   localparam logic [3:0] IDX_CC = 4'h6;
   localparam logic [3:0] IDX_CC_HI = 4'h7;
   localparam logic [3:0] IDX_CC_LO = 4'h8;
   localparam logic [3:0] IDX_CP_HI = 4'h9;
   localparam logic [3:0] IDX_CP_LO = 4'ha;
   localparam logic [3:0] IDX_CR_HI = 4'hb;
   localparam logic [3:0] IDX_CR_LO = 4'hc;
   localparam logic [3:0] IDX_LIM_HI = 4'hd;
   localparam logic [3:0] IDX_LIM_LO = 4'he;
   localparam logic [3:0] IDX_SPARE = 4'hf;
   localparam logic [3:0] IDX_ONE = 4'h1;
   localparam logic [SP_W-1:0] SP_RESET = 32'h0;
   // Rise slew keeps four decimals: one step is ten fine units
   localparam logic [SP_W-1:0] RISE_QUANTUM = 32'h0000000a;
   // ***************************************************
   // Set-up store: 15 banks of 10 states, 16 words each
   // ***************************************************
   localparam int unsigned SLOT_W = 8;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned STORE_DEPTH = 2400;
   localparam logic [7:0] STATES_PER_BANK = 8'h0a;
   localparam logic [3:0] STATE_MIN = 4'h1;
   localparam logic [3:0] STATE_MAX = 4'ha;
   localparam logic [3:0] BANK_MIN = 4'h1;
   localparam logic [3:0] BANK_MAX = 4'hf;
   // ***************************************************
   // Timing
   // ***************************************************
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned TICK_NS = 1000;
   localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);
   // One microsecond counted in 1e-5 ms
   localparam logic [SP_W-1:0] UNITS_PER_TICK = 32'h00000064;
   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [1:0] {OP_SET = 2'h0, OP_SAVE = 2'h1, OP_RECALL = 2'h2} lsch_op_t;
   typedef enum logic [2:0] {CLS_SLEW = 3'h0, CLS_TIME = 3'h1, CLS_VOLT = 3'h2, CLS_CURRENT_SETPOINT_CMD = 3'h3,
      CLS_POW = 3'h4, CLS_RES = 3'h5} lsch_class_t;
   typedef enum logic [3:0] {ST_IDLE = 4'b0001, ST_SAVE = 4'b0010, ST_RECALL = 4'b0100,
      ST_DRAIN = 4'b1000} lsch_state_t;
endpackage

// ===== testbench/lsch_host_model.sv
// Remote host stand-in: presents parsed text commands to the handler and collects each answer.
// Assumes the handler answers within 40 cycles of taking a command.
module lsch_host_model
   import lsch_pkg::*;
(
   input wire logic core_clk,
   input wire logic rspValid,
   input wire logic rspError,
   input wire logic [SP_W-1:0] rspData,
   output logic cmdValid,
   output logic [1:0] cmdOp,
   output logic [IDX_W-1:0] cmdTarget,
   output logic cmdQuery,
   output logic cmdHasArg,
   output logic cmdHasPoint,
   output logic cmdTerm,
   output logic [SP_W-1:0] cmdValue,
   output logic [3:0] cmdState,
   output logic [3:0] cmdBank
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {cmdValid, cmdOp, cmdTarget, cmdQuery, cmdHasArg, cmdHasPoint, cmdTerm, cmdState, cmdBank} = '0;
      cmdValue = '0;
   end
   // Argument, point and terminator flags come from the caller; faults are sent only on request
   task automatic issue(input logic [1:0] op, input logic [3:0] tgt, input logic q, a, p, t,
      input logic [SP_W-1:0] val, input logic [3:0] st, bk,
      output logic got, output logic err, output logic [SP_W-1:0] data);
      got = 1'h0;
      err = 1'hx;
      data = 'x;
      @(posedge core_clk);
      cmdValid <= 1'h1;
      cmdOp <= op;
      cmdTarget <= tgt;
      cmdQuery <= q;
      cmdHasArg <= a;
      cmdHasPoint <= p;
      cmdTerm <= t;
      cmdValue <= val;
      cmdState <= st;
      cmdBank <= bk;
      @(posedge core_clk);
      cmdValid <= 1'h0;
      // Bounded wait: a lost answer shows as got low instead of a hang
      for (int i = 0; i < 40 && !got; i++) begin
         @(posedge core_clk);
         if (rspValid === 1'h1) begin
            got = 1'h1;
            err = rspError;
            data = rspData;
         end
      end
   endtask
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench: a setpoint model in arrays of words is compared with every answer.
// Assumes the handler contract of one-cycle answers for set/query and sequenced save/recall.
module tb_top
   import lsch_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, rst_n, cmdValid, cmdQuery, cmdHasArg, cmdHasPoint, cmdTerm;
   logic dynEnable, levelSelHigh, singleLevel, ngEnable, cmdBusy, rspValid, rspError, waveHigh, loadOn, limitFail;
   logic [1:0] cmdOp;
   logic [IDX_W-1:0] cmdTarget;
   logic [3:0] cmdState, cmdBank;
   logic [SP_W-1:0] cmdValue, maxSlew, maxPeriod, maxVolt, maxCurrent, maxPower, maxRes, measVolt, measCurrent;
   logic [SP_W-1:0] rspData, slewRise, slewFall, currentDrive, powerDrive, resDrive;
   logic [SP_W-1:0] sp [16];
   logic [SP_W-1:0] img [16];
   int err_count = 0;
   int compares = 0;
   lsch_handler i_lsch_handler (.*);
   lsch_host_model i_lsch_host_model (.*);
   initial begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic give_verdict();
      $display("Compares %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string what, input logic [SP_W-1:0] seen, input logic [SP_W-1:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // ***************************************************
   // Model of the setpoint store
   // ***************************************************
   function automatic logic [SP_W-1:0] clamp(input logic [3:0] tgt, input logic [SP_W-1:0] val);
      logic [SP_W-1:0] m, r;
      m = tgt < 2 ? maxSlew : tgt < 4 ? maxPeriod : tgt < 6 ? maxVolt : tgt == 9 || tgt == 10 ? maxPower
         : tgt == 11 || tgt == 12 ? maxRes : maxCurrent;
      r = val > m ? m : val;
      return tgt == 0 ? r - r % 10 : r;
   endfunction
   task automatic do_cmd(input logic [1:0] op, input logic [3:0] tgt, input logic q, a, p, t,
      input logic [SP_W-1:0] val, input logic [3:0] st = 4'h1, input logic [3:0] bk = 4'h1);
      logic got, err, expErr;
      logic [SP_W-1:0] data, v;
      int ti;
      ti = tgt;
      v = clamp(tgt, val);
      expErr = !t || op == 2'h3 || (op == 2'h0 && (tgt == 4'hf || (!q && (!a || (ti inside {2, 3} && !p)
         || (ti inside {8, 10, 12, 14} && v > sp[ti - 1]) || (ti inside {7, 9, 11, 13} && v < sp[ti + 1])))))
         || (op != 2'h0 && (st < 4'h1 || st > 4'ha || bk < 4'h1 || bk > 4'hf));
      i_lsch_host_model.issue(op, tgt, q, a, p, t, val, st, bk, got, err, data);
      check("answer", {31'h0, got}, 32'h1);
      check("error", {31'h0, err}, {31'h0, expErr});
      if (q && !expErr && op == 2'h0)
         check("query", data, sp[ti]);
      if (!expErr && op == 2'h0 && !q)
         sp[ti] = v;
      if (!expErr && op == 2'h1)
         img = sp;
      if (!expErr && op == 2'h2)
         sp = img;
   endtask
   task automatic query_all();
      for (int k = 0; k < 15; k++)
         do_cmd(2'h0, 4'(k), 1'h1, 1'h0, 1'h0, 1'h1, '0);
   endtask
   // Flag read after the wait, not copied at the call
   task automatic settle_check(input string what, input logic limSel, input logic exp);
      repeat (3) @(posedge core_clk);
      check(what, {31'h0, limSel ? limitFail : loadOn}, {31'h0, exp});
   endtask
   // ***************************************************
   // Stimulus
   // ***************************************************
   initial begin
      rst_n = 1'h0;
      {dynEnable, levelSelHigh, singleLevel, ngEnable} = '0;
      maxSlew = 32'h000f4240;
      {maxPeriod, maxVolt, maxCurrent, maxPower, maxRes} = {5{32'h00989680}};
      {measVolt, measCurrent} = '0;
      for (int k = 0; k < 16; k++)
         sp[k] = '0;
      img = sp;
      void'($urandom(32'h7eccbadf));
      repeat (2) @(posedge core_clk);
      rst_n <= 1'h1;
      query_all();
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 15; k++)
            do_cmd(2'h0, 4'(k), 1'h0, 1'h1, 1'h1, 1'h1, $urandom_range(32'h00a00000, 0));
         @(posedge core_clk);
         {dynEnable, levelSelHigh, singleLevel} <= 3'($urandom);
         query_all();
      end
      do_cmd(2'h0, 4'h6, 1'h0, 1'h1, 1'h1, 1'h1, 32'hffffffff);
      do_cmd(2'h0, 4'h0, 1'h0, 1'h1, 1'h1, 1'h1, 32'h0001e24f);
      do_cmd(2'h0, 4'h0, 1'h0, 1'h0, 1'h1, 1'h1, 32'h00000064);
      do_cmd(2'h0, 4'h2, 1'h0, 1'h1, 1'h0, 1'h1, 32'h00000064);
      do_cmd(2'h0, 4'h6, 1'h0, 1'h1, 1'h1, 1'h0, 32'h00000064);
      do_cmd(2'h0, 4'hf, 1'h0, 1'h1, 1'h1, 1'h1, 32'h00000064);
      do_cmd(2'h3, 4'h6, 1'h0, 1'h1, 1'h1, 1'h1, 32'h00000064);
      for (int k = 7; k < 14; k += 2) begin
         do_cmd(2'h0, 4'(k + 1), 1'h0, 1'h1, 1'h1, 1'h1, '0);
         do_cmd(2'h0, 4'(k), 1'h0, 1'h1, 1'h1, 1'h1, 32'h000003e8);
         do_cmd(2'h0, 4'(k + 1), 1'h0, 1'h1, 1'h1, 1'h1, 32'h000007d0);
         do_cmd(2'h0, 4'(k + 1), 1'h0, 1'h1, 1'h1, 1'h1, 32'h000001f4);
         do_cmd(2'h0, 4'(k), 1'h0, 1'h1, 1'h1, 1'h1, 32'h00000190);
      end
      query_all();
      do_cmd(2'h1, 4'h0, 1'h0, 1'h0, 1'h0, 1'h1, '0, 4'ha, 4'hf);
      do_cmd(2'h0, 4'h6, 1'h0, 1'h1, 1'h1, 1'h1, 32'h00000457);
      do_cmd(2'h1, 4'h0, 1'h0, 1'h0, 1'h0, 1'h1, '0, 4'hb, 4'h1);
      do_cmd(2'h2, 4'h0, 1'h0, 1'h0, 1'h0, 1'h1, '0, 4'h1, 4'h0);
      do_cmd(2'h2, 4'h0, 1'h0, 1'h0, 1'h0, 1'h1, '0, 4'ha, 4'hf);
      query_all();
      do_cmd(2'h0, 4'h4, 1'h0, 1'h1, 1'h1, 1'h1, 32'h00124f80);
      do_cmd(2'h0, 4'h5, 1'h0, 1'h1, 1'h1, 1'h1, 32'h0007a120);
      measVolt <= 32'h0013d620;
      settle_check("switch on", 1'h0, 1'h1);
      measVolt <= 32'h000c3500;
      settle_check("hysteresis", 1'h0, 1'h1);
      measVolt <= 32'h00061a80;
      settle_check("switch off", 1'h0, 1'h0);
      do_cmd(2'h0, 4'he, 1'h0, 1'h1, 1'h1, 1'h1, '0);
      do_cmd(2'h0, 4'hd, 1'h0, 1'h1, 1'h1, 1'h1, 32'h000493e0);
      do_cmd(2'h0, 4'he, 1'h0, 1'h1, 1'h1, 1'h1, 32'h000186a0);
      ngEnable <= 1'h1;
      measCurrent <= 32'h00030d40;
      settle_check("inside limits", 1'h1, 1'h0);
      measCurrent <= 32'h00061a80;
      settle_check("above limit", 1'h1, 1'h1);
      measCurrent <= 32'h0000c350;
      settle_check("below limit", 1'h1, 1'h1);
      ngEnable <= 1'h0;
      settle_check("check off", 1'h1, 1'h0);
      do_cmd(2'h0, 4'h1, 1'h0, 1'h1, 1'h1, 1'h1, 32'h000f4240);
      {dynEnable, levelSelHigh, singleLevel} <= 3'h3;
      // Long enough for the slowest ramp up to the single level
      repeat (8000) @(posedge core_clk);
      check("rise slew", slewRise, sp[0]);
      check("fall slew", slewFall, sp[1]);
      check("single level", currentDrive, sp[6]);
      check("power high", powerDrive, sp[9]);
      check("res high", resDrive, sp[11]);
      check("wave idle", {31'h0, waveHigh}, 32'h0);
      {dynEnable, levelSelHigh, singleLevel} <= 3'h0;
      repeat (800) @(posedge core_clk);
      check("low level", currentDrive, sp[8]);
      check("power low", powerDrive, sp[10]);
      check("res low", resDrive, sp[12]);
      give_verdict();
   end
   initial begin
      #(25 * 40000);
      err_count++;
      give_verdict();
   end
endmodule
